// [inc/impact_spi_pkg.sv]
package impact_spi_pkg;
  // ==========================================================
  // Frame and word layout
  localparam int FRAME_BITS = 16;
  localparam int FRESH_POS = 15;
  localparam int FAULT_POS = 14;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [13:0] ZERO_DATA = 14'h0000;
  localparam logic [1:0] DONT_CARE_BITS = 2'h0;

  // ==========================================================
  // Device byte addresses (lower byte of each word, except DATA_LOW_END_ADDR, the last byte 0x0F)
  localparam logic [5:0] SUPPLY_ADDR = 6'h02;
  localparam logic [5:0] X_ACCEL_ADDR = 6'h04;
  localparam logic [5:0] Y_ACCEL_ADDR = 6'h06;
  localparam logic [5:0] AUX_ADDR = 6'h08;
  localparam logic [5:0] TEMP_ADDR = 6'h0A;
  localparam logic [5:0] X_PEAK_ADDR = 6'h0C;
  localparam logic [5:0] Y_PEAK_ADDR = 6'h0E;
  localparam logic [5:0] RSS_ADDR = 6'h18;
  localparam logic [5:0] RSS_PEAK_ADDR = 6'h1A;
  localparam logic [5:0] EVENT_ONE_ADDR = 6'h1C;
  localparam logic [5:0] EVENT_TWO_ADDR = 6'h1E;
  localparam logic [5:0] DATA_LOW_END_ADDR = 6'h0F;
  localparam logic [5:0] CTRL_FIRST_ADDR = 6'h20;
  // Word slots that carry a fresh-sample flag
  localparam logic [15:0] FRESH_SLOTS = 16'h30FE;

  // ==========================================================
  // Link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_HALF_NS = 200;
  localparam int CS_HIGH_NS = 400;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Host controller registers
  localparam logic [7:0] FRAME_WORD_OFS = 8'h00;
  localparam logic [7:0] RX_WORD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int BUSY_POS = 0;
  localparam int DONE_POS = 1;

  // Magnitude of a 14-bit twos complement value
  function automatic logic [13:0] mag14(input logic [13:0] v);
    return v[13] ? 14'(~v + 14'h0001) : v;
  endfunction : mag14
endpackage : impact_spi_pkg

// [inc/spi_link_if.sv]
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic dout_line;
  // Line pulled high while the device lets it float
  assign dout_line = dout_oe_n ? 1'b1 : dout;
  modport device (input cs_n, input sclk, input din, output dout, output dout_oe_n);
  modport host (output cs_n, output sclk, output din, input dout_line);
endinterface : spi_link_if

// [design/rss_magnitude.sv]
`timescale 1ns/1ps
module rss_magnitude (
  input wire logic [13:0] x_in,
  input wire logic [13:0] y_in,
  output logic [13:0] mag_out
);
  logic [13:0] ax_w;
  logic [13:0] ay_w;
  logic [27:0] sum_w;

  // ==========================================================
  // Sum of squares
  assign ax_w = impact_spi_pkg::mag14(x_in);
  assign ay_w = impact_spi_pkg::mag14(y_in);
  assign sum_w = 28'(ax_w) * 28'(ax_w) + 28'(ay_w) * 28'(ay_w);

  // Bitwise root unrolled in space; area traded for zero latency
  always_comb begin
    logic [13:0] root;
    logic [13:0] trial;
    root = 14'h0000;
    trial = 14'h0000;
    for (int i = 13; i >= 0; i--) begin
      trial = root | (14'h0001 << i);
      if (28'(trial) * 28'(trial) <= sum_w) begin
        root = trial;
      end
    end
    mag_out = root;
  end
endmodule : rss_magnitude

// [design/impact_sensor_port.sv]
`timescale 1ns/1ps
module impact_sensor_port (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  spi_link_if.device SPI,
  input wire logic SAMPLE_IN,
  input wire logic [13:0] X_ACCEL_IN,
  input wire logic [13:0] Y_ACCEL_IN,
  input wire logic [11:0] SUPPLY_IN,
  input wire logic [11:0] AUX_IN,
  input wire logic [11:0] TEMP_IN,
  input wire logic [15:0] EVENT_ONE_IN,
  input wire logic [15:0] EVENT_TWO_IN,
  input wire logic FAULT_IN,
  input wire logic PEAK_CLEAR_IN,
  output logic WR_VALID_OUT,
  output logic [5:0] WR_ADDR_OUT,
  output logic [7:0] WR_DATA_OUT
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic cs_prev_r;
  logic sclk_prev_r;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  logic [14:0] rx_sh_r;
  logic [4:0] rx_cnt_r;
  logic [15:0] rx_word;
  logic frame_done;
  logic rd_pend_r;
  logic [5:0] rd_addr_r;
  logic [15:0] tx_sh_r;
  logic first_fall_r;
  logic oe_n_r;
  logic [15:0] rd_word;
  logic [15:0] fresh_r;
  logic [15:0] fresh_clr;
  logic [11:0] supply_r;
  logic [11:0] aux_r;
  logic [11:0] temp_r;
  logic [13:0] x_r;
  logic [13:0] y_r;
  logic [13:0] rss_r;
  logic [13:0] x_pk_r;
  logic [13:0] y_pk_r;
  logic [13:0] rss_pk_r;
  logic [13:0] rss_w;
  logic wr_valid_r;
  logic [5:0] wr_addr_r;
  logic [7:0] wr_data_r;

  // Packs a result with its two flag bits
  function automatic logic [15:0] pack(input logic fresh, input logic fault, input logic [13:0] data);
    return {fresh, fault, data};
  endfunction : pack

  // Widens a 12-bit result, bits 13 and 12 forced low
  function automatic logic [13:0] wide12(input logic [11:0] v);
    return {impact_spi_pkg::DONT_CARE_BITS, v};
  endfunction : wide12

  // Keeps the larger of held and new value
  function automatic logic [13:0] peak_next(input logic [13:0] cur, input logic [13:0] val,
                                            input logic sgn, input logic clr);
    logic [13:0] mc;
    logic [13:0] mv;
    mc = sgn ? impact_spi_pkg::mag14(cur) : cur;
    mv = sgn ? impact_spi_pkg::mag14(val) : val;
    return (clr || mv > mc) ? val : cur;
  endfunction : peak_next

  // ==========================================================
  // Pin synchronisers and edge detection
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b1;
    end else if (CE_IN) begin
      meta_r <= {SPI.cs_n, SPI.sclk, SPI.din};
      sync_r <= meta_r;
      cs_prev_r <= sync_r[2];
      sclk_prev_r <= sync_r[1];
    end
  end

  assign cs_n_s = sync_r[2];
  assign sclk_s = sync_r[1];
  assign din_s = sync_r[0];
  assign frame_start = cs_prev_r & ~cs_n_s;
  assign frame_end = ~cs_prev_r & cs_n_s;
  // Clock edges count only inside a frame
  assign sclk_rise = ~cs_n_s & ~sclk_prev_r & sclk_s;
  assign sclk_fall = ~cs_n_s & sclk_prev_r & ~sclk_s;

  // ==========================================================
  // Receive shifter; clocks past the sixteenth are dropped
  assign rx_word = {rx_sh_r, din_s};
  assign frame_done = sclk_rise && rx_cnt_r == 5'(impact_spi_pkg::FRAME_BITS - 1);

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rx_sh_r <= 15'h0000;
      rx_cnt_r <= 5'h00;
    end else if (CE_IN) begin
      if (frame_start) begin
        rx_cnt_r <= 5'h00;
      end else if (sclk_rise && rx_cnt_r != 5'(impact_spi_pkg::FRAME_BITS)) begin
        rx_sh_r <= rx_word[14:0];
        rx_cnt_r <= rx_cnt_r + 5'h01;
      end
    end
  end

  // Read request held for the next frame; anything else cancels it
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= 6'h00;
    end else if (CE_IN) begin
      if (frame_done && rx_word[15:14] == impact_spi_pkg::OP_READ) begin
        rd_pend_r <= 1'b1;
        rd_addr_r <= rx_word[13:8];
      end else if (frame_done || frame_start) begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // Byte writes to 0x10-0x17 and to control space go out; result words are read-only
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      wr_valid_r <= 1'b0;
      wr_addr_r <= 6'h00;
      wr_data_r <= 8'h00;
    end else if (CE_IN) begin
      wr_valid_r <= 1'b0;
      if (frame_done && rx_word[15:14] == impact_spi_pkg::OP_WRITE) begin
        wr_addr_r <= rx_word[13:8];
        wr_data_r <= rx_word[7:0];
        wr_valid_r <= rx_word[13:8] > impact_spi_pkg::DATA_LOW_END_ADDR &&
                      (rx_word[13:8] < impact_spi_pkg::RSS_ADDR ||
                       rx_word[13:8] >= impact_spi_pkg::CTRL_FIRST_ADDR);
      end
    end
  end

  // ==========================================================
  // Read mux, both byte addresses of a word select it
  always_comb begin
    rd_word = impact_spi_pkg::ZERO_WORD;
    if (!rd_addr_r[5]) begin
      case (rd_addr_r[4:1])
        impact_spi_pkg::SUPPLY_ADDR[4:1]: rd_word = pack(fresh_r[1], FAULT_IN, wide12(supply_r));
        impact_spi_pkg::X_ACCEL_ADDR[4:1]: rd_word = pack(fresh_r[2], FAULT_IN, x_r);
        impact_spi_pkg::Y_ACCEL_ADDR[4:1]: rd_word = pack(fresh_r[3], FAULT_IN, y_r);
        impact_spi_pkg::AUX_ADDR[4:1]: rd_word = pack(fresh_r[4], FAULT_IN, wide12(aux_r));
        impact_spi_pkg::TEMP_ADDR[4:1]: rd_word = pack(fresh_r[5], FAULT_IN, wide12(temp_r));
        impact_spi_pkg::X_PEAK_ADDR[4:1]: rd_word = pack(fresh_r[6], FAULT_IN, x_pk_r);
        impact_spi_pkg::Y_PEAK_ADDR[4:1]: rd_word = pack(fresh_r[7], FAULT_IN, y_pk_r);
        impact_spi_pkg::RSS_ADDR[4:1]: rd_word = pack(fresh_r[12], FAULT_IN, rss_r);
        impact_spi_pkg::RSS_PEAK_ADDR[4:1]: rd_word = pack(fresh_r[13], FAULT_IN, rss_pk_r);
        impact_spi_pkg::EVENT_ONE_ADDR[4:1]: rd_word = EVENT_ONE_IN;
        impact_spi_pkg::EVENT_TWO_ADDR[4:1]: rd_word = EVENT_TWO_IN;
        default: rd_word = impact_spi_pkg::ZERO_WORD;
      endcase
    end
  end

  // ==========================================================
  // Transmit shifter; the first clock fall keeps the bit set at select fall
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tx_sh_r <= impact_spi_pkg::ZERO_WORD;
      first_fall_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else if (CE_IN) begin
      if (frame_start) begin
        tx_sh_r <= rd_pend_r ? rd_word : impact_spi_pkg::ZERO_WORD;
        first_fall_r <= 1'b1;
        oe_n_r <= 1'b0;
      end else if (frame_end) begin
        oe_n_r <= 1'b1;
      end else if (sclk_fall) begin
        first_fall_r <= 1'b0;
        if (!first_fall_r) begin
          tx_sh_r <= {tx_sh_r[14:0], 1'b0};
        end
      end
    end
  end

  assign SPI.dout = tx_sh_r[impact_spi_pkg::FRESH_POS];
  assign SPI.dout_oe_n = oe_n_r;

  // ==========================================================
  // Fresh flags: a new sample beats a read in the same cycle
  assign fresh_clr = (frame_start && rd_pend_r && !rd_addr_r[5]) ? (16'h0001 << rd_addr_r[4:1]) : 16'h0000;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fresh_r <= 16'h0000;
    end else if (CE_IN) begin
      fresh_r <= (SAMPLE_IN ? impact_spi_pkg::FRESH_SLOTS : 16'h0000) | (fresh_r & ~fresh_clr);
    end
  end

  // ==========================================================
  // Results, updated at sample rate whatever the reads do
  rss_magnitude u_rss (
    .x_in(X_ACCEL_IN),
    .y_in(Y_ACCEL_IN),
    .mag_out(rss_w)
  );

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      supply_r <= 12'h000;
      aux_r <= 12'h000;
      temp_r <= 12'h000;
      x_r <= impact_spi_pkg::ZERO_DATA;
      y_r <= impact_spi_pkg::ZERO_DATA;
      rss_r <= impact_spi_pkg::ZERO_DATA;
    end else if (CE_IN && SAMPLE_IN) begin
      supply_r <= SUPPLY_IN;
      aux_r <= AUX_IN;
      temp_r <= TEMP_IN;
      x_r <= X_ACCEL_IN;
      y_r <= Y_ACCEL_IN;
      rss_r <= rss_w;
    end
  end

  // Peaks; a clear with a sample restarts from that sample
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      x_pk_r <= impact_spi_pkg::ZERO_DATA;
      y_pk_r <= impact_spi_pkg::ZERO_DATA;
      rss_pk_r <= impact_spi_pkg::ZERO_DATA;
    end else if (CE_IN) begin
      if (PEAK_CLEAR_IN && !SAMPLE_IN) begin
        x_pk_r <= impact_spi_pkg::ZERO_DATA;
        y_pk_r <= impact_spi_pkg::ZERO_DATA;
        rss_pk_r <= impact_spi_pkg::ZERO_DATA;
      end else if (SAMPLE_IN) begin
        x_pk_r <= peak_next(x_pk_r, X_ACCEL_IN, 1'b1, PEAK_CLEAR_IN);
        y_pk_r <= peak_next(y_pk_r, Y_ACCEL_IN, 1'b1, PEAK_CLEAR_IN);
        rss_pk_r <= peak_next(rss_pk_r, rss_w, 1'b0, PEAK_CLEAR_IN);
      end
    end
  end

  assign WR_VALID_OUT = wr_valid_r;
  assign WR_ADDR_OUT = wr_addr_r;
  assign WR_DATA_OUT = wr_data_r;
endmodule : impact_sensor_port

// [design/impact_spi_host.sv]
`timescale 1ns/1ps
module impact_spi_host (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  spi_link_if.host SPI
);
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_GAP} host_state_t;

  host_state_t state_r;
  logic [4:0] tmr_r;
  logic [4:0] bit_r;
  logic [15:0] sh_r;
  logic [15:0] rx_sh_r;
  logic [15:0] rx_word_r;
  logic end_r;
  logic cs_n_r;
  logic sclk_r;
  logic din_r;
  logic dout_meta_r;
  logic dout_sync_r;
  logic [15:0] tx_word_r;
  logic start_r;
  logic done_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic access;
  logic complete;
  logic busy;
  logic rx_rd;

  // ==========================================================
  // APB slave: ready one cycle into the access phase
  assign access = PSEL_IN & PENABLE_IN & ~pready_r;
  assign complete = PSEL_IN & PENABLE_IN & pready_r;
  assign busy = start_r | (state_r != ST_IDLE);
  assign rx_rd = complete & ~PWRITE_IN & (PADDR_IN == impact_spi_pkg::RX_WORD_OFS);

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      tx_word_r <= 16'h0000;
      start_r <= 1'b0;
      done_r <= 1'b0;
    end else if (CE_IN) begin
      pready_r <= access;
      start_r <= 1'b0;
      // Completion of a frame beats a clearing read
      done_r <= end_r | (done_r & ~rx_rd);
      if (access) begin
        pslverr_r <= 1'b0;
        case (PADDR_IN)
          impact_spi_pkg::FRAME_WORD_OFS: prdata_r <= {16'h0000, tx_word_r};
          impact_spi_pkg::RX_WORD_OFS: prdata_r <= {16'h0000, rx_word_r};
          impact_spi_pkg::STATUS_OFS: prdata_r <= 32'({done_r, busy});
          default: begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b1;
          end
        endcase
      end
      // Writes while a frame runs are dropped
      if (complete && PWRITE_IN && PADDR_IN == impact_spi_pkg::FRAME_WORD_OFS && !busy) begin
        tx_word_r <= PWDATA_IN[15:0];
        start_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Returned data line crosses into this clock
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      dout_meta_r <= 1'b1;
      dout_sync_r <= 1'b1;
    end else if (CE_IN) begin
      dout_meta_r <= SPI.dout_line;
      dout_sync_r <= dout_meta_r;
    end
  end

  // ==========================================================
  // Frame engine; clock idles high, data changes on falls
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_r <= ST_IDLE;
      tmr_r <= 5'h00;
      bit_r <= 5'h00;
      sh_r <= 16'h0000;
      rx_sh_r <= 16'h0000;
      rx_word_r <= 16'h0000;
      end_r <= 1'b0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b1;
      din_r <= 1'b1;
    end else if (CE_IN) begin
      end_r <= 1'b0;
      if (tmr_r != 5'h00) begin
        tmr_r <= tmr_r - 5'h01;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (start_r) begin
              cs_n_r <= 1'b0;
              din_r <= tx_word_r[15];
              sh_r <= {tx_word_r[14:0], 1'b0};
              bit_r <= 5'h00;
              tmr_r <= 5'(impact_spi_pkg::SCLK_HALF_CYC - 1);
              state_r <= ST_LEAD;
            end
          end
          ST_LEAD: begin
            sclk_r <= 1'b0;
            tmr_r <= 5'(impact_spi_pkg::SCLK_HALF_CYC - 1);
            state_r <= ST_LOW;
          end
          ST_LOW: begin
            sclk_r <= 1'b1;
            rx_sh_r <= {rx_sh_r[14:0], dout_sync_r};
            bit_r <= bit_r + 5'h01;
            tmr_r <= 5'(impact_spi_pkg::SCLK_HALF_CYC - 1);
            state_r <= ST_HIGH;
          end
          ST_HIGH: begin
            if (bit_r == 5'(impact_spi_pkg::FRAME_BITS)) begin
              cs_n_r <= 1'b1;
              rx_word_r <= rx_sh_r;
              end_r <= 1'b1;
              tmr_r <= 5'(impact_spi_pkg::CS_HIGH_CYC - 1);
              state_r <= ST_GAP;
            end else begin
              sclk_r <= 1'b0;
              din_r <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'b0};
              tmr_r <= 5'(impact_spi_pkg::SCLK_HALF_CYC - 1);
              state_r <= ST_LOW;
            end
          end
          ST_GAP: state_r <= ST_IDLE;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign SPI.cs_n = cs_n_r;
  assign SPI.sclk = sclk_r;
  assign SPI.din = din_r;
  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
endmodule : impact_spi_host

// [tb/impact_link_chk.sv]
`timescale 1ns/1ps
module impact_link_chk (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe_n
);
  // ==========================================================
  // Rise count per frame
  logic sclk_q_r;
  logic [4:0] rises_r;

  // Cleared while deselected, so a frame count survives to the select rise
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sclk_q_r <= 1'b1;
      rises_r <= 5'h00;
    end else begin
      sclk_q_r <= sclk;
      if (cs_n) begin
        rises_r <= 5'h00;
      end else if (sclk && !sclk_q_r) begin
        rises_r <= rises_r + 5'h01;
      end
    end
  end

  // ==========================================================
  // Link properties
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  property p_float_idle;
    cs_n [*5] |-> dout_oe_n;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("data out driven while idle");
  property p_drive_frame;
    $fell(cs_n) |-> ##[1:5] !dout_oe_n;
  endproperty
  a_drive_frame: assert property (p_drive_frame) else $error("data out not driven in frame");
  property p_release;
    $rose(cs_n) |-> ##[1:5] dout_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("data out not released");
  property p_sclk_idle;
    cs_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock low while idle");
  property p_half;
    $fell(sclk) |-> (!sclk) [*8] ##1 sclk;
  endproperty
  a_half: assert property (p_half) else $error("serial clock low phase length");
  property p_gap;
    $rose(cs_n) |-> cs_n [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
  property p_count;
    $rose(cs_n) |-> rises_r == 5'h10;
  endproperty
  a_count: assert property (p_count) else $error("frame not sixteen clocks");
  property p_dout_hold;
    $rose(sclk) && !cs_n |-> ##1 $stable(dout) [*6];
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("data out moved in high phase");
  property p_din_hold;
    $rose(sclk) && !cs_n |-> $stable(din) ##1 $stable(din);
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("data in moved at sample edge");
endmodule : impact_link_chk

// [tb/impact_sensor_spi_register_port_tb.sv]
`timescale 1ns/1ps
module impact_sensor_spi_register_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, wr_v;
  logic sample = 1'b0;
  logic fault = 1'b0;
  logic pclr = 1'b0;
  logic [13:0] xin = 14'h0;
  logic [13:0] yin = 14'h0;
  logic [11:0] sup = 12'h0;
  logic [11:0] aux = 12'h0;
  logic [11:0] tmp = 12'h0;
  logic [15:0] ev1 = 16'h0;
  logic [15:0] ev2 = 16'h0;
  logic [5:0] wr_a;
  logic [7:0] wr_d;
  logic [13:0] xp = 14'h0;
  logic [13:0] yp = 14'h0;
  logic [13:0] rp = 14'h0;
  logic [13:0] rss = 14'h0;
  logic [15:0] fresh = 16'h0;
  int err_total, n_compared, cyc, wr_cnt;

  // ==========================================================
  // Both ends joined over one link
  spi_link_if spi_link_if_inst();
  impact_spi_host impact_spi_host_inst (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SPI(spi_link_if_inst));
  impact_sensor_port impact_sensor_port_inst (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1),
    .SPI(spi_link_if_inst), .SAMPLE_IN(sample), .X_ACCEL_IN(xin), .Y_ACCEL_IN(yin), .SUPPLY_IN(sup),
    .AUX_IN(aux), .TEMP_IN(tmp), .EVENT_ONE_IN(ev1), .EVENT_TWO_IN(ev2), .FAULT_IN(fault),
    .PEAK_CLEAR_IN(pclr), .WR_VALID_OUT(wr_v), .WR_ADDR_OUT(wr_a), .WR_DATA_OUT(wr_d));
  impact_link_chk impact_link_chk_inst (.CLK_IN(clk), .RSTN_IN(rstn), .cs_n(spi_link_if_inst.cs_n),
    .sclk(spi_link_if_inst.sclk), .din(spi_link_if_inst.din), .dout(spi_link_if_inst.dout),
    .dout_oe_n(spi_link_if_inst.dout_oe_n));

  // Clock at 40 MHz
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Write pulses counted; cycle ceiling stops a hung handshake
  always @(posedge clk) begin
    cyc++;
    if (wr_v === 1'b1) wr_cnt++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Request held until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One frame: start, wait for done with busy gone, fetch received word
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    logic [31:0] q;
    logic e;
    apb(1'b1, impact_spi_pkg::FRAME_WORD_OFS, {16'h0000, w}, q, e);
    q = 32'h0;
    while (q[1:0] !== 2'b10) apb(1'b0, impact_spi_pkg::STATUS_OFS, 32'h0, q, e);
    apb(1'b0, impact_spi_pkg::RX_WORD_OFS, 32'h0, q, e);
    r = q[15:0];
  endtask : xfer

  function automatic logic [13:0] amag(input logic [13:0] v);
    return v[13] ? 14'(-v) : v;
  endfunction : amag

  // Expected word for a byte address; either byte gives the whole word
  function automatic logic [15:0] expw(input logic [5:0] a);
    case (a[5:1])
      5'h01: return {fresh[1], fault, 2'b00, sup};
      5'h02: return {fresh[2], fault, xin};
      5'h03: return {fresh[3], fault, yin};
      5'h04: return {fresh[4], fault, 2'b00, aux};
      5'h05: return {fresh[5], fault, 2'b00, tmp};
      5'h06: return {fresh[6], fault, xp};
      5'h07: return {fresh[7], fault, yp};
      5'h0C: return {fresh[12], fault, rss};
      5'h0D: return {fresh[13], fault, rp};
      5'h0E: return ev1;
      5'h0F: return ev2;
      default: return 16'h0000;
    endcase
  endfunction : expw

  // ==========================================================
  // One round: sample with peak handling, writes, full read pass
  task automatic round(input int mode);
    int k, n;
    logic [13:0] nx, ny;
    logic [15:0] r;
    logic [5:0] a;
    logic [7:0] d;
    k = $urandom_range(1600, 1);
    nx = 14'(3 * k);
    ny = 14'(4 * k);
    if ($urandom_range(1, 0) == 1) nx = 14'(-nx);
    if ($urandom_range(1, 0) == 1) ny = 14'(-ny);
    if (mode == 3) begin
      @(posedge clk);
      pclr <= 1'b1;
    end
    @(posedge clk);
    pclr <= (mode == 1);
    sample <= 1'b1;
    xin <= nx;
    yin <= ny;
    sup <= 12'($urandom);
    aux <= 12'($urandom);
    tmp <= 12'($urandom);
    ev1 <= 16'($urandom);
    ev2 <= 16'($urandom);
    fault <= 1'($urandom);
    @(posedge clk);
    sample <= 1'b0;
    pclr <= 1'b0;
    // Clear, alone or with a sample, leaves only the new value
    if (mode != 2) begin
      xp = 14'h0;
      yp = 14'h0;
      rp = 14'h0;
    end
    rss = 14'(5 * k);
    if (amag(nx) > amag(xp)) xp = nx;
    if (amag(ny) > amag(yp)) yp = ny;
    if (rss > rp) rp = rss;
    fresh = impact_spi_pkg::FRESH_SLOTS;
    n = wr_cnt;
    d = 8'($urandom);
    a = ($urandom_range(1, 0) == 1) ? 6'(16 + $urandom_range(7, 0)) : 6'(32 + $urandom_range(31, 0));
    xfer({impact_spi_pkg::OP_WRITE, a, d}, r);
    chk("write pulse", wr_cnt, n + 1);
    chk("write byte", {18'h0, wr_a, wr_d}, {18'h0, a, d});
    // Other byte of the same word goes out as a byte write of its own
    xfer({impact_spi_pkg::OP_WRITE, a ^ 6'h01, ~d}, r);
    chk("second byte", {18'h0, wr_a, wr_d}, {18'h0, a ^ 6'h01, ~d});
    xfer({impact_spi_pkg::OP_WRITE, 6'h04, d}, r);
    chk("read-only write", wr_cnt, n + 2);
    xfer({impact_spi_pkg::OP_READ, 6'h00, 8'h00}, r);
    // Pipelined reads: each answer belongs to the previous request
    for (int i = 1; i <= 32; i++) begin
      xfer({impact_spi_pkg::OP_READ, 6'(i % 32), 8'($urandom)}, r);
      chk("read word", {16'h0, r}, {16'h0, expw(6'(i - 1))});
      fresh[(i - 1) / 2] = 1'b0;
    end
    $display("round %0d done", mode);
  endtask : round

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] r;
    int n;
    void'($urandom(32'h8A8379C8));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, impact_spi_pkg::STATUS_OFS, 32'h0, q, e);
    chk("status reset", q, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("unmapped data", q, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    $display("host register test done");
    for (int m = 1; m <= 3; m++) round(m);
    // Control-space read answers zero; undefined op codes neither read nor write
    n = wr_cnt;
    xfer({impact_spi_pkg::OP_READ, 6'h2A, 8'h00}, r);
    xfer({2'h1, impact_spi_pkg::X_ACCEL_ADDR, 8'h00}, r);
    chk("control read", {16'h0, r}, 32'h0);
    xfer({2'h3, 6'h12, 8'h5A}, r);
    chk("undefined op read", {16'h0, r}, 32'h0);
    chk("undefined op write", wr_cnt, n);
    $display("control space test done");
    chk("idle float", {31'h0, spi_link_if_inst.dout_oe_n}, 32'h1);
    wrap_up();
  end
endmodule : impact_sensor_spi_register_port_tb
